// ===== verilog/sram_consts.vh
// Register offsets, field positions, reset values and timing counts for the SRAM control block
`ifndef SRAM_CONSTS_VH
`define SRAM_CONSTS_VH

`define SRAM_WB_AW              4
`define SRAM_REG_CTRL           4'h0
`define SRAM_REG_STATUS         4'h4
`define SRAM_REG_SLEEPS         4'h8
`define SRAM_REG_STALLS         4'hc

`define SRAM_CTRL_FORCE_SLEEP   0
`define SRAM_CTRL_RESET         1'b0

`define SRAM_STAT_ASLEEP        0
`define SRAM_STAT_ACTIVE        1
`define SRAM_STAT_OP_WRITE      2
`define SRAM_STAT_WBUF_VALID    3
`define SRAM_STAT_BURST_CNT     4
`define SRAM_STAT_SELECTED      6

`define SRAM_CNT_RESET          16'h0000
`define SRAM_BURST_LINEAR       1'b0
`define SRAM_BURST_INTERLEAVED  1'b1

// Sleep entry and exit bound, in clock periods, and the derived cycle count
`define SRAM_SLEEP_BOUND_PERIODS 2
`define SRAM_CLK_PER_PERIOD      1
`define SRAM_SLEEP_BOUND_CYCLES  (`SRAM_SLEEP_BOUND_PERIODS * `SRAM_CLK_PER_PERIOD)

`endif

// ===== verilog/sram_word_array.v
// Storage array with byte-lane writes and registered read data
`timescale 1ns/1ns
module sram_word_array #(
    parameter AW = 21,
    parameter BW = 9,
    parameter NB = 2,
    parameter DW = BW * NB
) (
    input  wire          core_clk,
    input  wire          readEn,
    input  wire [AW-1:0] readAddr,
    output reg  [DW-1:0] readData,
    input  wire          writeEn,
    input  wire [AW-1:0] writeAddr,
    input  wire [DW-1:0] writeData,
    input  wire [NB-1:0] writeLanes
);

    reg [DW-1:0] mem [0:(1<<AW)-1];
    integer      i;

    // Read returns the old word on a same-address write; the caller merges
    always @(posedge core_clk) begin
        if (readEn) begin
            readData <= mem[readAddr];
        end
        if (writeEn) begin
            for (i = 0; i < NB; i = i + 1) begin
                if (writeLanes[i]) begin
                    mem[writeAddr][i*BW +: BW] <= writeData[i*BW +: BW];
                end
            end
        end
    end

endmodule // sram_word_array

// ===== verilog/sram_sleep_ctrl.v
// Synchronous burst SRAM cycle control, sleep handling and register port
`timescale 1ns/1ns
`include "sram_consts.vh"
module sram_sleep_ctrl #(
    parameter AW = 21,
    parameter BW = 9,
    parameter NB = 2,
    parameter DW = BW * NB
) (
    input  wire                    core_clk,
    input  wire                    nrst,
    input  wire                    sleepRequest,
    input  wire                    holdCycleN,
    input  wire                    advanceNotLoad,
    input  wire                    primarySelectN,
    input  wire                    secondarySelectN,
    input  wire                    secondarySelect,
    input  wire                    readNotWrite,
    input  wire [NB-1:0]           byteLaneWriteN,
    input  wire                    outputEnableN,
    input  wire                    burstOrder,
    input  wire [AW-1:0]           addrIn,
    input  wire [DW-1:0]           dataIn,
    output reg  [DW-1:0]           dataOut,
    output reg                     dataOutEnN,
    input  wire                    cyc_i,
    input  wire                    stb_i,
    input  wire                    we_i,
    input  wire [`SRAM_WB_AW-1:0]  adr_i,
    input  wire [3:0]              sel_i,
    input  wire [31:0]             dat_i,
    output reg  [31:0]             dat_o,
    output reg                     ack_o
);

    // Functions
    function [1:0] burstLow;
        input [1:0] base;
        input [1:0] count;
        input       interleaved;
        begin
            if (interleaved == `SRAM_BURST_INTERLEAVED) begin
                burstLow = base ^ count;
            end else begin
                burstLow = base + count;
            end
        end
    endfunction

    function [DW-1:0] laneMerge;
        input [DW-1:0] older;
        input [DW-1:0] newer;
        input [NB-1:0] lanes;
        integer k;
        begin
            laneMerge = older;
            for (k = 0; k < NB; k = k + 1) begin
                if (lanes[k]) begin
                    laneMerge[k*BW +: BW] = newer[k*BW +: BW];
                end
            end
        end
    endfunction

    // Sleep synchroniser and software force
    reg sleepMeta_q;
    reg sleepSync_q;
    reg forceSleep_q;

    // Synchronised level: at most two edges from pin change to effect
    always @(posedge core_clk) begin
        if (!nrst) begin
            sleepMeta_q <= 1'b0;
            sleepSync_q <= 1'b0;
        end else begin
            sleepMeta_q <= sleepRequest | forceSleep_q;
            sleepSync_q <= sleepMeta_q;
        end
    end

    wire asleep = sleepSync_q;
    // Enabled edge: not stalled and not asleep
    wire advance = !holdCycleN && !asleep;
    wire selected = !primarySelectN && !secondarySelectN && secondarySelect;
    // Chip enables only count on load edges
    wire isLoad = !advanceNotLoad && selected;
    wire isDeselect = !advanceNotLoad && !selected;

    // Burst state: the cycle type is fixed at the load edge, continues reuse it
    localparam [2:0] BURST_IDLE  = 3'b001;
    localparam [2:0] BURST_READ  = 3'b010;
    localparam [2:0] BURST_WRITE = 3'b100;

    reg  [2:0]    burstState_q;
    reg  [2:0]    burstState_d;
    reg  [AW-1:0] baseAddr_q;
    reg  [1:0]    burstCnt_q;

    wire          burstActive = (burstState_q != BURST_IDLE);
    wire          burstWrite = (burstState_q == BURST_WRITE);
    wire          isContinue = advanceNotLoad && burstActive;
    wire [1:0]    nextCnt = burstCnt_q + 2'd1;
    wire [AW-1:0] burstAddr = {baseAddr_q[AW-1:2],
                               burstLow(baseAddr_q[1:0], nextCnt, burstOrder)};
    wire [AW-1:0] cmdAddr = isLoad ? addrIn : burstAddr;
    wire          cmdRead = advance && (isLoad ? readNotWrite : (isContinue && !burstWrite));
    wire          cmdWrite = advance && (isLoad ? !readNotWrite : (isContinue && burstWrite));
    wire [NB-1:0] cmdLanes = ~byteLaneWriteN;

    // Sleep and deselect end a burst; an unknown code falls back to idle
    always @* begin
        burstState_d = burstState_q;
        if (asleep) begin
            burstState_d = BURST_IDLE;
        end else if (advance && isLoad) begin
            burstState_d = readNotWrite ? BURST_READ : BURST_WRITE;
        end else if (advance) begin
            case (burstState_q)
                BURST_READ, BURST_WRITE: begin
                    if (isDeselect) begin
                        burstState_d = BURST_IDLE;
                    end
                end
                default: begin
                    burstState_d = BURST_IDLE;
                end
            endcase
        end
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            burstState_q <= BURST_IDLE;
            baseAddr_q   <= {AW{1'b0}};
            burstCnt_q   <= 2'b00;
        end else begin
            burstState_q <= burstState_d;
            if (advance && isLoad) begin
                baseAddr_q <= addrIn;
                burstCnt_q <= 2'b00;
            end else if (advance && isContinue) begin
                burstCnt_q <= nextCnt;
            end
        end
    end

    // Pipeline: reads drive one enabled edge later, writes capture two later
    reg          rdPend_q;
    reg [AW-1:0] rdAddr_q;
    reg          wr1_q;
    reg [AW-1:0] wr1Addr_q;
    reg [NB-1:0] wr1Lanes_q;
    reg          wr2_q;
    reg [AW-1:0] wr2Addr_q;
    reg [NB-1:0] wr2Lanes_q;

    // Operations in flight at sleep entry are dropped, host waits first
    always @(posedge core_clk) begin
        if (!nrst || asleep) begin
            rdPend_q   <= 1'b0;
            wr1_q      <= 1'b0;
            wr2_q      <= 1'b0;
            rdAddr_q   <= {AW{1'b0}};
            wr1Addr_q  <= {AW{1'b0}};
            wr2Addr_q  <= {AW{1'b0}};
            wr1Lanes_q <= {NB{1'b0}};
            wr2Lanes_q <= {NB{1'b0}};
        end else if (advance) begin
            rdPend_q   <= cmdRead;
            rdAddr_q   <= cmdAddr;
            wr1_q      <= cmdWrite;
            wr1Addr_q  <= cmdAddr;
            wr1Lanes_q <= cmdLanes;
            wr2_q      <= wr1_q;
            wr2Addr_q  <= wr1Addr_q;
            wr2Lanes_q <= wr1Lanes_q;
        end
    end

    // Input data register: newest write waits here until the next one
    reg          wbufValid_q;
    reg [AW-1:0] wbufAddr_q;
    reg [DW-1:0] wbufData_q;
    reg [NB-1:0] wbufLanes_q;
    reg          lcValid_q;
    reg [AW-1:0] lcAddr_q;
    reg [DW-1:0] lcData_q;
    reg [NB-1:0] lcLanes_q;

    // All-lanes-off write is an abort and leaves the buffer alone
    wire captureNow = advance && wr2_q && (|wr2Lanes_q);
    wire commitNow = captureNow && wbufValid_q;

    always @(posedge core_clk) begin
        if (!nrst) begin
            wbufValid_q <= 1'b0;
            wbufAddr_q  <= {AW{1'b0}};
            wbufData_q  <= {DW{1'b0}};
            wbufLanes_q <= {NB{1'b0}};
        end else if (captureNow) begin
            wbufValid_q <= 1'b1;
            wbufAddr_q  <= wr2Addr_q;
            wbufData_q  <= dataIn;
            wbufLanes_q <= wr2Lanes_q;
        end
    end

    // Remembers what reached the array on the last enabled edge
    always @(posedge core_clk) begin
        if (!nrst) begin
            lcValid_q <= 1'b0;
            lcAddr_q  <= {AW{1'b0}};
            lcData_q  <= {DW{1'b0}};
            lcLanes_q <= {NB{1'b0}};
        end else if (advance) begin
            lcValid_q <= commitNow;
            lcAddr_q  <= wbufAddr_q;
            lcData_q  <= wbufData_q;
            lcLanes_q <= wbufLanes_q;
        end
    end

    wire [DW-1:0] arrayData;

    sram_word_array #(
        .AW (AW),
        .BW (BW),
        .NB (NB),
        .DW (DW)
    ) array (
        .core_clk   (core_clk),
        .readEn     (cmdRead),
        .readAddr   (cmdAddr),
        .readData   (arrayData),
        .writeEn    (commitNow),
        .writeAddr  (wbufAddr_q),
        .writeData  (wbufData_q),
        .writeLanes (wbufLanes_q)
    );

    // Coherent read: array, then last commit, buffer, and data arriving now
    wire [NB-1:0] lcHit = (lcValid_q && lcAddr_q == rdAddr_q) ? lcLanes_q : {NB{1'b0}};
    wire [NB-1:0] wbHit = (wbufValid_q && wbufAddr_q == rdAddr_q) ? wbufLanes_q : {NB{1'b0}};
    wire [NB-1:0] inHit = (captureNow && wr2Addr_q == rdAddr_q) ? wr2Lanes_q : {NB{1'b0}};
    wire [DW-1:0] readMerged = laneMerge(laneMerge(laneMerge(arrayData, lcData_q, lcHit),
                                                   wbufData_q, wbHit),
                                         dataIn, inHit);

    // Output drive
    reg  driving_q;
    // A stalled edge keeps whatever the bus was doing
    wire driveNext = asleep ? 1'b0 : (advance ? rdPend_q : driving_q);

    always @(posedge core_clk) begin
        if (!nrst) begin
            driving_q  <= 1'b0;
            dataOut    <= {DW{1'b0}};
            dataOutEnN <= 1'b1;
        end else begin
            driving_q <= driveNext;
            if (advance && rdPend_q) begin
                dataOut <= readMerged;
            end
            // Write phases never set driveNext, so output enable is moot there
            dataOutEnN <= !driveNext || outputEnableN;
        end
    end

    // Activity counters visible to software
    reg        asleepSeen_q;
    reg [15:0] sleepCount_q;
    reg [15:0] stallCount_q;

    always @(posedge core_clk) begin
        if (!nrst) begin
            asleepSeen_q <= 1'b0;
            sleepCount_q <= `SRAM_CNT_RESET;
            stallCount_q <= `SRAM_CNT_RESET;
        end else begin
            asleepSeen_q <= asleep;
            if (asleep && !asleepSeen_q) begin
                sleepCount_q <= sleepCount_q + 16'h0001;
            end
            if (holdCycleN && !asleep) begin
                stallCount_q <= stallCount_q + 16'h0001;
            end
        end
    end

    // Status word
    wire [31:0] statusWord;
    assign statusWord[`SRAM_STAT_ASLEEP]     = asleep;
    assign statusWord[`SRAM_STAT_ACTIVE]     = burstActive;
    assign statusWord[`SRAM_STAT_OP_WRITE]   = burstWrite;
    assign statusWord[`SRAM_STAT_WBUF_VALID] = wbufValid_q;
    assign statusWord[`SRAM_STAT_BURST_CNT +: 2] = burstCnt_q;
    assign statusWord[`SRAM_STAT_SELECTED]   = selected;
    assign statusWord[31:7] = 25'h0000000;

    // Wishbone classic slave, one wait state, unmapped reads return zero
    wire wbReq = cyc_i && stb_i && !ack_o;

    always @(posedge core_clk) begin
        if (!nrst) begin
            ack_o        <= 1'b0;
            dat_o        <= 32'h00000000;
            forceSleep_q <= `SRAM_CTRL_RESET;
        end else begin
            ack_o <= wbReq;
            if (wbReq) begin
                if (adr_i == `SRAM_REG_CTRL) begin
                    dat_o <= {31'h00000000, forceSleep_q};
                    if (we_i && sel_i[0]) begin
                        forceSleep_q <= dat_i[`SRAM_CTRL_FORCE_SLEEP];
                    end
                end else if (adr_i == `SRAM_REG_STATUS) begin
                    dat_o <= statusWord;
                end else if (adr_i == `SRAM_REG_SLEEPS) begin
                    dat_o <= {16'h0000, sleepCount_q};
                end else if (adr_i == `SRAM_REG_STALLS) begin
                    dat_o <= {16'h0000, stallCount_q};
                end else begin
                    dat_o <= 32'h00000000;
                end
            end
        end
    end

endmodule // sram_sleep_ctrl

// ===== verification/sram_sleep_ctrl_chk.sv
// Port assertions for the SRAM sleep and cycle control block
`timescale 1ns/1ns
module sram_sleep_ctrl_chk #(
    parameter DW = 18
) (
    input wire          core_clk,
    input wire          nrst,
    input wire          sleepRequest,
    input wire          holdCycleN,
    input wire          advanceNotLoad,
    input wire          primarySelectN,
    input wire          secondarySelectN,
    input wire          secondarySelect,
    input wire          readNotWrite,
    input wire          outputEnableN,
    input wire [DW-1:0] dataOut,
    input wire          dataOutEnN,
    input wire          cyc_i,
    input wire          stb_i,
    input wire          ack_o
);
    // Pin low long enough that the synchroniser surely reads awake
    reg  [1:0] lowCnt_q;
    wire       awake  = (lowCnt_q == 2'd3) && !sleepRequest;
    wire       sel    = !primarySelectN && !secondarySelectN && secondarySelect;
    wire       load   = awake && !holdCycleN && !advanceNotLoad;
    wire       wrLoad = load && sel && !readNotWrite;
    wire       rdLoad = load && sel && readNotWrite && !outputEnableN;
    wire       dsLoad = load && !sel;
    wire       step   = awake && !holdCycleN;
    wire       stall  = awake && holdCycleN;
    always @(posedge core_clk) begin
        if (!nrst || sleepRequest)
            lowCnt_q <= 2'd0;
        else if (lowCnt_q != 2'd3)
            lowCnt_q <= lowCnt_q + 2'd1;
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    chk_sleep_undriven: assert property (sleepRequest [*4] |=> dataOutEnN)
        else $error("data bus driven while asleep");
    chk_sleep_frozen: assert property (sleepRequest [*6] |-> $stable(dataOut))
        else $error("read data changed while asleep");
    chk_write_undriven: assert property (wrLoad ##1 step |=> dataOutEnN)
        else $error("data bus driven in write phase");
    chk_read_drives: assert property (rdLoad ##1 step && !outputEnableN |=> !dataOutEnN)
        else $error("selected read not driven");
    chk_deselect_quiet: assert property (dsLoad ##1 step |=> dataOutEnN)
        else $error("deselected cycle drove the bus");
    chk_stall_holds: assert property (stall |=> $stable({dataOut, dataOutEnN}))
        else $error("stalled edge changed the data bus");
    chk_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    chk_ack_unasked: assert property (!ack_o && !(cyc_i && stb_i) |=> !ack_o)
        else $error("ack without request");
    cov_write: cover property (wrLoad ##1 step);
    cov_stall: cover property (stall);
    cov_sleep: cover property (sleepRequest [*6]);
endmodule // sram_sleep_ctrl_chk

bind sram_sleep_ctrl sram_sleep_ctrl_chk #(.DW(DW)) u_chk (
    .core_clk(core_clk), .nrst(nrst), .sleepRequest(sleepRequest), .holdCycleN(holdCycleN),
    .advanceNotLoad(advanceNotLoad), .primarySelectN(primarySelectN),
    .secondarySelectN(secondarySelectN), .secondarySelect(secondarySelect),
    .readNotWrite(readNotWrite), .outputEnableN(outputEnableN), .dataOut(dataOut),
    .dataOutEnN(dataOutEnN), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o));

// ===== verification/sram_host_model.sv
// Host memory controller model driving the SRAM pins
`timescale 1ns/1ns
module sram_host_model #(
    parameter AW = 6,
    parameter DW = 18
) (
    input  wire          core_clk,
    output reg           sleepRequest     = 1'b0,
    output reg           holdCycleN       = 1'b0,
    output reg           advanceNotLoad   = 1'b0,
    output reg           primarySelectN   = 1'b1,
    output reg           secondarySelectN = 1'b1,
    output reg           secondarySelect  = 1'b0,
    output reg           readNotWrite     = 1'b1,
    output reg  [1:0]    byteLaneWriteN   = 2'b11,
    output reg           outputEnableN    = 1'b0,
    output reg           burstOrder       = 1'b0,
    output reg  [AW-1:0] addrIn           = '0,
    output reg  [DW-1:0] dataIn           = '0
);
    // Enables always carry a definite level on every edge
    task cmd(input h, input adv, input [2:0] en, input rnw, input [1:0] ln,
             input [AW-1:0] a, input [DW-1:0] d);
        begin
            @(posedge core_clk);
            holdCycleN       <= h;
            advanceNotLoad   <= adv;
            primarySelectN   <= !en[0];
            secondarySelectN <= !en[1];
            secondarySelect  <= en[2];
            readNotWrite     <= rnw;
            byteLaneWriteN   <= ln;
            // Output enable is meaningless in writes, so it wanders there
            outputEnableN    <= rnw ? 1'b0 : ($urandom & 1) != 0;
            addrIn           <= a;
            dataIn           <= d;
        end
    endtask
    task aux(input order, input sleep);
        begin
            @(posedge core_clk);
            burstOrder   <= order;
            sleepRequest <= sleep;
        end
    endtask
endmodule // sram_host_model

// ===== verification/sram_sleep_ctrl_tb.sv
// Self-checking bench for the SRAM sleep and cycle control block
`timescale 1ns/1ns
`include "sram_consts.vh"
module sram_sleep_ctrl_tb;
    localparam AW = 6;
    localparam DW = 18;
    reg                    core_clk = 1'b0;
    reg                    nrst     = 1'b0;
    reg                    cyc_i    = 1'b0;
    reg                    stb_i    = 1'b0;
    reg                    we_i     = 1'b0;
    reg  [`SRAM_WB_AW-1:0] adr_i    = 4'h0;
    reg  [3:0]             sel_i    = 4'h0;
    reg  [31:0]            dat_i    = 32'h0;
    wire [31:0]            dat_o;
    wire                   ack_o, sleepRequest, holdCycleN, advanceNotLoad, primarySelectN;
    wire                   secondarySelectN, secondarySelect, readNotWrite, outputEnableN;
    wire                   burstOrder, dataOutEnN;
    wire [1:0]             byteLaneWriteN;
    wire [AW-1:0]          addrIn;
    wire [DW-1:0]          dataIn, dataOut;
    reg  [DW-1:0]          mem [0:63];
    reg  [DW-1:0]          old;
    reg  [AW-1:0]          a;
    reg  [31:0]            rdv;
    integer                bad_count = 0;
    integer                compares  = 0;
    integer                i, k;
    sram_sleep_ctrl #(.AW(AW)) u_sram_sleep_ctrl (
        .core_clk(core_clk), .nrst(nrst), .sleepRequest(sleepRequest),
        .holdCycleN(holdCycleN), .advanceNotLoad(advanceNotLoad),
        .primarySelectN(primarySelectN), .secondarySelectN(secondarySelectN),
        .secondarySelect(secondarySelect), .readNotWrite(readNotWrite),
        .byteLaneWriteN(byteLaneWriteN), .outputEnableN(outputEnableN),
        .burstOrder(burstOrder), .addrIn(addrIn), .dataIn(dataIn), .dataOut(dataOut),
        .dataOutEnN(dataOutEnN), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o));
    sram_host_model #(.AW(AW), .DW(DW)) u_sram_host_model (
        .core_clk(core_clk), .sleepRequest(sleepRequest), .holdCycleN(holdCycleN),
        .advanceNotLoad(advanceNotLoad), .primarySelectN(primarySelectN),
        .secondarySelectN(secondarySelectN), .secondarySelect(secondarySelect),
        .readNotWrite(readNotWrite), .byteLaneWriteN(byteLaneWriteN),
        .outputEnableN(outputEnableN), .burstOrder(burstOrder), .addrIn(addrIn),
        .dataIn(dataIn));
    initial forever #2 core_clk = ~core_clk;
    task complete_run;
        begin
            if (bad_count == 0 && compares > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    task chkReg(input [95:0] what, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    task chkData(input [95:0] what, input [DW-1:0] exp, input [DW-1:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("unexpected %0s: expected %h, seen %h", what, exp, got);
            end
        end
    endtask
    function [DW-1:0] merge(input [DW-1:0] o, input [DW-1:0] n, input [1:0] ln);
        begin
            merge = o;
            if (!ln[0]) merge[8:0] = n[8:0];
            if (!ln[1]) merge[17:9] = n[17:9];
        end
    endfunction
    task wb(input wr, input [3:0] adr, input [31:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge core_clk);
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            we_i  <= wr;
            adr_i <= adr;
            dat_i <= d;
            sel_i <= 4'hf;
            n = 0;
            @(posedge core_clk);
            while (ack_o !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge core_clk);
            end
            chkReg("busAck", 32'h1, {31'h0, ack_o});
            q = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            sel_i <= 4'h0;
        end
    endtask
    task idle;
        u_sram_host_model.cmd(1'b0, 1'b0, 3'b000, 1'b1, 2'b11, AW'($urandom), DW'($urandom));
    endtask
    task rd(input [AW-1:0] ra);
        begin
            u_sram_host_model.cmd(1'b0, 1'b0, 3'b111, 1'b1, 2'b11, ra, DW'($urandom));
            idle;
            idle;
            #1;
            chkData("readData", mem[ra], dataOut);
            chkData("readDrive", 0, dataOutEnN);
        end
    endtask
    task wr(input [AW-1:0] wa, input [1:0] ln, input [DW-1:0] d, input st, input [2:0] en);
        begin
            u_sram_host_model.cmd(1'b0, 1'b0, en, 1'b0, ln, wa, ~d);
            if (st)
                u_sram_host_model.cmd(1'b1, 1'b0, 3'b000, 1'b1, 2'b11, wa, ~d);
            idle;
            u_sram_host_model.cmd(1'b0, 1'b0, 3'b000, 1'b1, 2'b11, ~wa, d);
            if (en == 3'b111)
                mem[wa] = merge(mem[wa], d, ln);
        end
    endtask
    task burst(input [AW-1:0] b, input o);
        reg [1:0] lo;
        begin
            u_sram_host_model.aux(o, 1'b0);
            u_sram_host_model.cmd(1'b0, 1'b0, 3'b111, 1'b1, 2'b11, b, DW'($urandom));
            for (k = 0; k < 5; k = k + 1) begin
                // Address pins wander on continue edges and must not matter
                u_sram_host_model.cmd(1'b0, k < 3, 3'($urandom), 1'b1, 2'b11, AW'($urandom),
                                      DW'($urandom));
                if (k > 0) begin
                    #1;
                    lo = o ? b[1:0] ^ 2'(k - 1) : b[1:0] + 2'(k - 1);
                    chkData("burstData", mem[{b[AW-1:2], lo}], dataOut);
                end
            end
        end
    endtask
    initial begin
        k = $urandom(32'h2f7c);
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        // Only the control bit is writable; a misaligned offset reads zero
        for (i = 0; i < 5; i = i + 1) begin
            wb(1'b1, i == 4 ? 4'h2 : 4'(i * 4), 32'hffff_fffe, rdv);
            wb(1'b0, i == 4 ? 4'h2 : 4'(i * 4), 32'h0, rdv);
            chkReg("regReset", 32'h0, rdv);
        end
        for (i = 0; i < 64; i = i + 1)
            wr(AW'(i), 2'b00, DW'($urandom), 1'b0, 3'b111);
        for (i = 0; i < 40; i = i + 1) begin
            a = AW'($urandom);
            wr(a, 2'($urandom), DW'($urandom), i % 4 == 0, 3'b111);
            rd(a);
            rd(AW'($urandom));
        end
        wb(1'b0, `SRAM_REG_STALLS, 32'h0, rdv);
        chkReg("stallCount", 32'd10, rdv);
        for (i = 0; i < 3; i = i + 1) begin
            wr(AW'(5), 2'b00, ~mem[5], 1'b0, 3'b111 ^ (3'b001 << i));
            rd(AW'(5));
        end
        for (i = 0; i < 8; i = i + 1)
            burst(AW'($urandom), i[0]);
        // Last burst may leave a load read on the pins; let it finish
        repeat (2) idle;
        // First by the pin, then by the control bit; the host is idle first
        for (i = 0; i < 2; i = i + 1) begin
            a = AW'($urandom);
            old = mem[a];
            if (i == 0)
                u_sram_host_model.aux(1'b0, 1'b1);
            else
                wb(1'b1, `SRAM_REG_CTRL, 32'h1, rdv);
            repeat (3) idle;
            wb(1'b0, `SRAM_REG_STATUS, 32'h0, rdv);
            chkReg("asleep", 32'h1, rdv & 32'h1);
            wb(1'b0, `SRAM_REG_SLEEPS, 32'h0, rdv);
            chkReg("sleepCount", i + 1, rdv);
            wb(1'b0, `SRAM_REG_CTRL, 32'h0, rdv);
            chkReg("ctrl", i, rdv);
            wr(a, 2'b00, ~old, 1'b0, 3'b111);
            mem[a] = old;
            #1;
            chkData("sleepDrive", 1, dataOutEnN);
            if (i == 0)
                u_sram_host_model.aux(1'b0, 1'b0);
            else
                wb(1'b1, `SRAM_REG_CTRL, 32'h0, rdv);
            repeat (3) idle;
            rd(a);
        end
        complete_run;
    end
    initial begin
        #40000;
        bad_count = bad_count + 1;
        complete_run;
    end
endmodule // sram_sleep_ctrl_tb
